// ---- hw/sip_pkg.sv ----
// constants and types shared by the serial/infrared port configuration block
package sip_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_S1_MODE = 8'hF0;
    localparam logic [7:0] IDX_S2_MODE = 8'hF3;
    localparam logic [7:0] IDX_IR_OPT = 8'hF1;
    localparam logic [7:0] IDX_HD_TMO = 8'hF2;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hF4;
    localparam logic [7:0] IDX_IRQ_EN = 8'hF5;
    localparam logic [7:0] IDX_IRQ_CLR = 8'hF6;
    // field positions
    localparam int B_MIDI = 0;
    localparam int B_HS = 1;
    localparam int B_SHARE = 7;
    localparam int B_TXIDLE = 5;
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_IR_OPT = 8'h02;
    localparam logic [7:0] RST_HD_TMO = 8'h03;
    // infrared function codes
    typedef enum logic [2:0] {
        SIP_IR_STD = 3'b000,
        SIP_IR_IRDA = 3'b001,
        SIP_IR_ASK = 3'b010
    } sip_ir_mode_t;
    // infrared option register layout, bit 7 downto bit 0
    typedef struct packed {
        logic rsvd;
        logic alt_pins;
        logic [2:0] mode;
        logic half_duplex;
        logic tx_low;
        logic rx_low;
    } sip_ir_opt_t;
    // timeout step, as a time and as a cycle count
    localparam int CLK_NS = 10;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
    // interrupt event bits
    localparam int EV_IRQ1 = 0;
    localparam int EV_IRQ2 = 1;
    localparam int EV_BLANK_END = 2;
    localparam int NUM_EV = 3;
endpackage : sip_pkg

// ---- hw/sip_config.sv ----
// serial and infrared port configuration bank with wishbone slave
//
// How it works
// - mode bit 0 enables midi, reset off
// - mode bit 1 enables high speed, reset off
// - port one bit 7 shares one interrupt
// - shared: both interrupt lines follow either port
// - port two bit 5: idle low or tristate
// - ir option bit 0 inverts receive input
// - ir option bit 1 inverts transmit output
// - ir option bit 2 selects half duplex
// - bits 5:3 pick standard, irda, ask
// - bit 6 moves infrared to alternate pins
// - timeout register counts 100 us steps
// - zero blanks only while transmitting
// - tx idle bit reset by standby reset only
`timescale 1ns/1ns
`default_nettype none
module sip_config #(
    parameter int TICK_CYCLES = sip_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_por_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // uart cores, same clock
    input wire logic first_serial_port_irq_i,
    input wire logic second_serial_port_irq_i,
    input wire logic second_serial_port_txd_i,
    input wire logic second_serial_port_tx_busy_i,
    output logic second_serial_port_rxd_o,
    output logic port1_irq_o,
    output logic port2_irq_o,
    output logic [1:0] midi_en_o,
    output logic [1:0] high_speed_o,
    output logic [2:0] ir_mode_o,
    // pins
    input wire logic second_port_rx_pin_i,
    output logic second_port_tx_pin_o,
    output logic second_port_tx_pin_oe_o,
    input wire logic alternate_ir_rx_pin_i,
    output logic alternate_ir_tx_pin_o,
    output logic irq_o
);
    import sip_pkg::*;

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic [7:0] s1_mode; // defined bits only, reserved read zero
    logic [1:0] s2_mode;
    logic tx_idle_tristate_select; // standby domain bit
    sip_ir_opt_t ir_opt;
    logic [7:0] hd_tmo;
    logic [NUM_EV-1:0] ev_stat; // sticky event bits
    logic [NUM_EV-1:0] ev_en;
    logic [NUM_EV-1:0] ev_set;
    logic [7:0] idx; // word index from byte address
    logic wr; // write takes effect on the ack edge
    logic [31:0] next_dat;
    logic rx_meta; // synchroniser first stages
    logic rx_sync;
    logic alt_meta;
    logic alt_sync;
    logic ir_on; // an infrared function is selected
    logic busy_q; // transmitter busy, last cycle
    logic tx_end;
    logic [7:0] blank_cnt; // remaining 100 us steps
    logic [15:0] pre_cnt; // tick prescaler
    logic blank;
    logic blank_q;
    logic irq1_q;
    logic irq2_q;
    logic raw_rx;

    assign idx = adr_i[9:2];
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    // reserved codes fall back to plain serial operation
    assign ir_on = (ir_opt.mode == SIP_IR_IRDA) ||
                   (ir_opt.mode == SIP_IR_ASK);
    assign tx_end = busy_q && !second_serial_port_tx_busy_i;
    // the cycle that loads the counter would otherwise leave a hole
    assign blank = second_serial_port_tx_busy_i || (tx_end && hd_tmo != 8'h00) ||
                   (blank_cnt != 8'h00);

    // -----------------------------------------------------------------
    // wishbone handshake
    // -----------------------------------------------------------------
    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    // read mux; unmapped and write-only indices read zero
    always_comb
    begin
        next_dat = 32'h0000_0000;
        case (idx)
            IDX_S1_MODE:
                next_dat[7:0] = s1_mode;
            IDX_S2_MODE:
                next_dat[7:0] = {2'b00, tx_idle_tristate_select,
                                 3'b000, s2_mode};
            IDX_IR_OPT:
                next_dat[7:0] = ir_opt;
            IDX_HD_TMO:
                next_dat[7:0] = hd_tmo;
            IDX_IRQ_STAT:
                next_dat[NUM_EV-1:0] = ev_stat;
            IDX_IRQ_EN:
                next_dat[NUM_EV-1:0] = ev_en;
            default:
                next_dat = 32'h0000_0000;
        endcase
    end

    // read data is latched with the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (cyc_i && stb_i && !ack_o)
            dat_o <= next_dat;
    end

    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    // port one mode; reserved bits are not stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s1_mode <= RST_MODE;
        else if (wr && idx == IDX_S1_MODE)
        begin
            s1_mode[B_MIDI] <= dat_i[B_MIDI];
            s1_mode[B_HS] <= dat_i[B_HS];
            s1_mode[B_SHARE] <= dat_i[B_SHARE];
        end
    end

    // port two mode, main domain bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s2_mode <= RST_MODE[1:0];
        else if (wr && idx == IDX_S2_MODE)
            s2_mode <= dat_i[1:0];
    end

    // idle bit survives ordinary resets, only standby reset clears it
    always_ff @(posedge clk_i)
    begin
        if (standby_por_i)
            tx_idle_tristate_select <= 1'b0;
        else if (wr && idx == IDX_S2_MODE)
            tx_idle_tristate_select <= dat_i[B_TXIDLE];
    end

    // infrared option; bit 7 is forced to zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ir_opt <= RST_IR_OPT;
        else if (wr && idx == IDX_IR_OPT)
            ir_opt <= {1'b0, dat_i[6:0]};
    end

    // half duplex timeout
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hd_tmo <= RST_HD_TMO;
        else if (wr && idx == IDX_HD_TMO)
            hd_tmo <= dat_i[7:0];
    end

    // mode outputs straight from the register flops
    assign midi_en_o = {s2_mode[B_MIDI], s1_mode[B_MIDI]};
    assign high_speed_o = {s2_mode[B_HS], s1_mode[B_HS]};
    assign ir_mode_o = ir_opt.mode;

    // -----------------------------------------------------------------
    // interrupt routing
    // -----------------------------------------------------------------
    // sharing ors both sources onto both lines; the external irq
    // assignment decides which line actually reaches the host
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port1_irq_o <= 1'b0;
            port2_irq_o <= 1'b0;
        end
        else if (s1_mode[B_SHARE])
        begin
            port1_irq_o <= first_serial_port_irq_i || second_serial_port_irq_i;
            port2_irq_o <= first_serial_port_irq_i || second_serial_port_irq_i;
        end
        else
        begin
            port1_irq_o <= first_serial_port_irq_i;
            port2_irq_o <= second_serial_port_irq_i;
        end
    end

    // -----------------------------------------------------------------
    // half duplex blanking timer
    // -----------------------------------------------------------------
    // prescaler restarts at tx end so the first step is a full 100 us
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_q <= 1'b0;
            blank_cnt <= 8'h00;
            pre_cnt <= 16'h0000;
        end
        else
        begin
            busy_q <= second_serial_port_tx_busy_i;
            if (tx_end)
            begin
                blank_cnt <= hd_tmo;
                pre_cnt <= 16'h0000;
            end
            else if (blank_cnt != 8'h00)
            begin
                if (pre_cnt == 16'(TICK_CYCLES - 1))
                begin
                    pre_cnt <= 16'h0000;
                    blank_cnt <= blank_cnt - 8'h01;
                end
                else
                    pre_cnt <= pre_cnt + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // receive path
    // -----------------------------------------------------------------
    // two flop synchronisers for both receive pins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            alt_meta <= 1'b0;
            alt_sync <= 1'b0;
        end
        else
        begin
            rx_meta <= second_port_rx_pin_i;
            rx_sync <= rx_meta;
            alt_meta <= alternate_ir_rx_pin_i;
            alt_sync <= alt_meta;
        end
    end

    assign raw_rx = ir_opt.alt_pins ? alt_sync : rx_sync;

    // polarity and blanking apply only in an infrared function
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            second_serial_port_rxd_o <= 1'b1;
        else if (!ir_on)
            second_serial_port_rxd_o <= rx_sync;
        else if (ir_opt.half_duplex && blank)
            second_serial_port_rxd_o <= 1'b0;
        else
            second_serial_port_rxd_o <= raw_rx ^ ir_opt.rx_low;
    end

    // -----------------------------------------------------------------
    // transmit path
    // -----------------------------------------------------------------
    // normal pin carries uart data, or infrared when not rerouted
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            second_port_tx_pin_o <= 1'b0;
            second_port_tx_pin_oe_o <= 1'b1;
        end
        else if (ir_on && !ir_opt.alt_pins)
        begin
            second_port_tx_pin_o <= second_serial_port_txd_i ^ ir_opt.tx_low;
            second_port_tx_pin_oe_o <= 1'b1;
        end
        else if (second_serial_port_tx_busy_i)
        begin
            second_port_tx_pin_o <= second_serial_port_txd_i;
            second_port_tx_pin_oe_o <= 1'b1;
        end
        else
        begin
            second_port_tx_pin_o <= 1'b0;
            second_port_tx_pin_oe_o <= !tx_idle_tristate_select;
        end
    end

    // alternate pin rests at the inactive infrared level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alternate_ir_tx_pin_o <= 1'b1;
        else if (ir_on && ir_opt.alt_pins)
            alternate_ir_tx_pin_o <= second_serial_port_txd_i ^ ir_opt.tx_low;
        else
            alternate_ir_tx_pin_o <= ir_opt.tx_low;
    end

    // -----------------------------------------------------------------
    // event status, enable, clear and interrupt line
    // -----------------------------------------------------------------
    // events: rising port interrupts and end of blanking
    assign ev_set = {blank_q && !blank,
                     second_serial_port_irq_i && !irq2_q,
                     first_serial_port_irq_i && !irq1_q};

    // edge memory for event detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            blank_q <= 1'b0;
            irq1_q <= 1'b0;
            irq2_q <= 1'b0;
        end
        else
        begin
            blank_q <= blank;
            irq1_q <= first_serial_port_irq_i;
            irq2_q <= second_serial_port_irq_i;
        end
    end

    // per bit sticky status; a new event beats a clear
    for (genvar g = 0; g < NUM_EV; g++)
    begin : g_ev
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                ev_stat[g] <= 1'b0;
            else if (ev_set[g])
                ev_stat[g] <= 1'b1;
            else if (wr && idx == IDX_IRQ_CLR && dat_i[g])
                ev_stat[g] <= 1'b0;
        end
    end

    // enable register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_en <= '0;
        else if (wr && idx == IDX_IRQ_EN)
            ev_en <= dat_i[NUM_EV-1:0];
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(ev_stat & ev_en);
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_MIDI_WRITE: assert property (
        $past(wr && idx == IDX_S1_MODE) |->
        midi_en_o[0] == $past(dat_i[0]))
        else $error("midi enable not written");
    AST_HS_WRITE: assert property (
        $past(wr && idx == IDX_S2_MODE) |->
        high_speed_o[1] == $past(dat_i[1]))
        else $error("high speed not written");
    AST_SEPARATE: assert property (
        !s1_mode[B_SHARE] |=> port2_irq_o == $past(second_serial_port_irq_i))
        else $error("separate irq wrong");
    AST_SHARED: assert property (
        s1_mode[B_SHARE] && first_serial_port_irq_i |=> port2_irq_o && port1_irq_o)
        else $error("shared irq missing");
    AST_IDLE_TRI: assert property (
        !second_serial_port_tx_busy_i && !ir_on && tx_idle_tristate_select
        |=> !second_port_tx_pin_oe_o)
        else $error("idle pin driven");
    AST_TX_POL: assert property (
        ir_on && !ir_opt.alt_pins |=>
        second_port_tx_pin_o == $past(second_serial_port_txd_i ^ ir_opt.tx_low))
        else $error("ir tx polarity");
    AST_RX_POL: assert property (
        ir_on && !ir_opt.half_duplex |=>
        second_serial_port_rxd_o == $past(raw_rx ^ ir_opt.rx_low))
        else $error("ir rx polarity");
    AST_HALF_BLANK: assert property (
        ir_on && ir_opt.half_duplex && second_serial_port_tx_busy_i |=> !second_serial_port_rxd_o)
        else $error("rx not blanked");
    AST_EXTEND: assert property (
        tx_end && hd_tmo != 8'h00 |-> blank [*8])
        else $error("blank not extended");
    AST_ALT_ROUTE: assert property (
        !ir_on |=> alternate_ir_tx_pin_o == $past(ir_opt.tx_low))
        else $error("alt pin not idle");
    AST_STANDBY: assert property (
        disable iff (standby_por_i)
        rst_i && !standby_por_i && !wr |=> $stable(tx_idle_tristate_select))
        else $error("idle bit lost on reset");

    COV_SHARE: cover property (s1_mode[B_SHARE] && second_serial_port_irq_i);
    COV_BLANK_END: cover property (ev_set[EV_BLANK_END]);
    COV_IRQ: cover property (irq_o);
endmodule : sip_config
`default_nettype wire

// ---- test/sip_config_tb.sv ----
// self-checking bench for the serial and infrared configuration bank
`timescale 1ns/1ns
`default_nettype none
module sip_config_tb;
    import sip_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and stimulus signals
    // ------------------------------------------------------------
    localparam int TICK = 16; // shortened 100 us step for simulation
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic standby_por_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic u1_irq = 1'b0;
    logic u2_irq = 1'b0;
    logic u2_txd = 1'b0;
    logic u2_busy = 1'b0;
    logic rx_pin = 1'b1;
    logic alt_rx_pin = 1'b1;
    logic second_serial_port_rxd_o, port1_irq_o, port2_irq_o, tx_pin_o, tx_oe_o;
    logic alt_tx_o, irq_o;
    logic [1:0] midi_en_o, high_speed_o;
    logic [2:0] ir_mode_o;
    logic [31:0] q; // last read value
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    // free-running clock, 10 ns period
    always #5 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------
    sip_config #(.TICK_CYCLES(TICK)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .standby_por_i(standby_por_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .first_serial_port_irq_i(u1_irq), .second_serial_port_irq_i(u2_irq),
        .second_serial_port_txd_i(u2_txd), .second_serial_port_tx_busy_i(u2_busy),
        .second_serial_port_rxd_o(second_serial_port_rxd_o), .port1_irq_o(port1_irq_o),
        .port2_irq_o(port2_irq_o), .midi_en_o(midi_en_o),
        .high_speed_o(high_speed_o), .ir_mode_o(ir_mode_o),
        .second_port_rx_pin_i(rx_pin), .second_port_tx_pin_o(tx_pin_o),
        .second_port_tx_pin_oe_o(tx_oe_o),
        .alternate_ir_rx_pin_i(alt_rx_pin),
        .alternate_ir_tx_pin_o(alt_tx_o), .irq_o(irq_o)
    );
    // ------------------------------------------------------------
    // reporting and bus tasks
    // ------------------------------------------------------------
    // verdict, reached from the main sequence or the timeout
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // register value compare
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    // single output level compare
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit
    // one classic cycle; held until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [7:0] idx,
                            input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n == 50)
        begin
            fails++;
            end_of_test();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb_cycle
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb_cycle(1'b1, idx, d, 4'h1);
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        wb_cycle(1'b0, idx, 8'h00, 4'h1);
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : waitc
    // hang guard: ceiling well above the expected run length
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        waitc(3);
        rst_i <= 1'b0;
        standby_por_i <= 1'b0;
        // reset values of the four configuration registers, plus an unmapped index
        rd(IDX_S1_MODE); chk_reg(q, 32'h00);
        rd(IDX_S2_MODE); chk_reg(q, 32'h00);
        rd(IDX_IR_OPT); chk_reg(q, 32'h02);
        rd(IDX_HD_TMO); chk_reg(q, 32'h03);
        rd(8'h10); chk_reg(q, 32'h00);
        $display("test reset_values done");
        // mode bits; reserved bits do not stick
        wr(IDX_S1_MODE, 8'hFF); rd(IDX_S1_MODE); chk_reg(q, 32'h83);
        chk_reg({30'h0, midi_en_o}, 32'h1);
        chk_reg({30'h0, high_speed_o}, 32'h1);
        wr(IDX_S1_MODE, 8'h00);
        wr(IDX_S2_MODE, 8'hDF); rd(IDX_S2_MODE); chk_reg(q, 32'h03);
        chk_reg({30'h0, midi_en_o}, 32'h2);
        chk_reg({30'h0, high_speed_o}, 32'h2);
        wb_cycle(1'b1, IDX_S2_MODE, 8'h00, 4'h0); // lane off: ignored
        rd(IDX_S2_MODE); chk_reg(q, 32'h03);
        wr(IDX_S2_MODE, 8'h00);
        $display("test mode_bits done");
        // interrupt routing, separate then shared
        u1_irq <= 1'b1;
        waitc(3);
        chk_bit(port1_irq_o, 1'b1);
        chk_bit(port2_irq_o, 1'b0);
        wr(IDX_S1_MODE, 8'h80);
        waitc(3);
        chk_bit(port2_irq_o, 1'b1);
        u1_irq <= 1'b0;
        u2_irq <= 1'b1;
        waitc(3);
        chk_bit(port1_irq_o, 1'b1);
        u2_irq <= 1'b0;
        wr(IDX_S1_MODE, 8'h00);
        $display("test irq_share done");
        // every infrared function code; bit 7 forced to zero
        for (int c = 0; c < 3; c++)
        begin
            wr(IDX_IR_OPT, {2'b00, 3'(c), 3'b000});
            waitc(1);
            chk_reg({29'h0, ir_mode_o}, 32'(c));
        end
        wr(IDX_IR_OPT, 8'hFF); rd(IDX_IR_OPT); chk_reg(q, 32'h7F);
        $display("test ir_codes done");
        // transmit polarity and pin routing in the pulse mode
        u2_txd <= 1'b1;
        wr(IDX_IR_OPT, 8'h08);
        waitc(4);
        chk_bit(tx_pin_o, 1'b1);
        wr(IDX_IR_OPT, 8'h0A);
        waitc(4);
        chk_bit(tx_pin_o, 1'b0);
        wr(IDX_IR_OPT, 8'h48);
        waitc(4);
        chk_bit(alt_tx_o, 1'b1);
        u2_txd <= 1'b0;
        // receive polarity and routing
        alt_rx_pin <= 1'b0;
        waitc(6);
        chk_bit(second_serial_port_rxd_o, 1'b0);
        wr(IDX_IR_OPT, 8'h09);
        waitc(6);
        chk_bit(second_serial_port_rxd_o, 1'b0);
        alt_rx_pin <= 1'b1;
        $display("test ir_polarity done");
        // duplex and blanking extension
        wr(IDX_IR_OPT, 8'h08);
        u2_busy <= 1'b1;
        waitc(6);
        chk_bit(second_serial_port_rxd_o, 1'b1);
        wr(IDX_IR_OPT, 8'h0C);
        waitc(6);
        chk_bit(second_serial_port_rxd_o, 1'b0);
        wr(IDX_HD_TMO, 8'h00);
        u2_busy <= 1'b0;
        waitc(6);
        chk_bit(second_serial_port_rxd_o, 1'b1);
        wr(IDX_HD_TMO, 8'h02);
        wr(IDX_IRQ_CLR, 8'h07);
        u2_busy <= 1'b1;
        waitc(4);
        u2_busy <= 1'b0;
        waitc(12);
        chk_bit(second_serial_port_rxd_o, 1'b0);
        waitc(TICK);
        chk_bit(second_serial_port_rxd_o, 1'b0);
        waitc(TICK);
        chk_bit(second_serial_port_rxd_o, 1'b1);
        rd(IDX_IRQ_STAT); chk_reg(q, 32'h04);
        wr(IDX_IR_OPT, 8'h00);
        $display("test blanking done");
        // interrupt status, enable, mask and clear
        wr(IDX_IRQ_CLR, 8'h07); rd(IDX_IRQ_STAT); chk_reg(q, 32'h00);
        u1_irq <= 1'b1;
        waitc(3);
        rd(IDX_IRQ_STAT); chk_reg(q, 32'h01);
        chk_bit(irq_o, 1'b0);
        wr(IDX_IRQ_EN, 8'h01); waitc(3); chk_bit(irq_o, 1'b1);
        wr(IDX_IRQ_EN, 8'h02); waitc(3); chk_bit(irq_o, 1'b0);
        wr(IDX_IRQ_STAT, 8'h00); rd(IDX_IRQ_STAT); chk_reg(q, 32'h01);
        wr(IDX_IRQ_CLR, 8'h01); rd(IDX_IRQ_STAT); chk_reg(q, 32'h00);
        wr(IDX_IRQ_EN, 8'h01); waitc(3); chk_bit(irq_o, 1'b0);
        u1_irq <= 1'b0;
        $display("test interrupts done");
        // idle level of the transmit pin and its standby-only reset
        waitc(3);
        chk_bit(tx_pin_o, 1'b0);
        chk_bit(tx_oe_o, 1'b1);
        wr(IDX_S2_MODE, 8'h20);
        waitc(3);
        chk_bit(tx_oe_o, 1'b0);
        rst_i <= 1'b1;
        waitc(2);
        rst_i <= 1'b0;
        rd(IDX_S2_MODE); chk_reg(q, 32'h20);
        standby_por_i <= 1'b1;
        waitc(2);
        standby_por_i <= 1'b0;
        rd(IDX_S2_MODE); chk_reg(q, 32'h00);
        waitc(3);
        chk_bit(tx_oe_o, 1'b1);
        $display("test tx_idle done");
        end_of_test();
    end
endmodule : sip_config_tb
`default_nettype wire
